/* verilog/bsil_pkg.sv */
// Purpose: constants and types for the boundary scan instruction logic
// Assumes: TAP pins are sampled by the 100 MHz system clock
// Notes:   instruction codes are 4 bits and shift in lsb first
// Behaviour
// - each pin has one boundary cell of three register cells: out, enable, input
// - sample/preload and extest place the whole boundary chain between tdi and tdo
// - boundary chain length equals three times the pin count
// - each cell has three capture stages and two holding stages
// - capture stages sample pin values and shift scan data under tap control
// - first stage captures core output data or drives scanned output data
// - second stage captures core enable or drives scanned enable
// - third stage captures the pin input buffer value
// - code 0Fh selects bypass
// - code 01h selects sample/preload, snapshot without disturbing the pins
// - code 03h selects extest, drive held patterns and capture inputs
// - code 02h selects idcode, a 32-bit word shifted out
// - code 04h selects highz, all pins released
// - code 07h selects the vendor mode scan register
// - code 08h routes shifted data into the command register
// - command 01h pulses master clear without resetting the tap
// - command 02h remaps tdi, tdo, tck to serial programming lines
// - after the remap only the standard programming method is offered
// - instruction register is 4 bits, shifted lsb first then decoded
// - command register is 8 bits, between tdi and tdo under 08h
package bsil_pkg;
    localparam int          IR_W        = 4;
    localparam int          CMD_W       = 8;
    localparam int          ID_W        = 32;
    localparam int          MODE_W      = 8;
    localparam int          CELL_BITS   = 3;
    localparam int          CELL_OUT    = 0;
    localparam int          CELL_OE     = 1;
    localparam int          CELL_IN     = 2;
    localparam logic [3:0]  IR_SAMPLE   = 4'h1;
    localparam logic [3:0]  IR_IDCODE   = 4'h2;
    localparam logic [3:0]  IR_EXTEST   = 4'h3;
    localparam logic [3:0]  IR_HIGHZ    = 4'h4;
    localparam logic [3:0]  IR_MODESCAN = 4'h7;
    localparam logic [3:0]  IR_CMD      = 4'h8;
    localparam logic [3:0]  IR_BYPASS   = 4'hf;
    localparam logic [3:0]  IR_CAPTURE  = 4'h1;
    localparam logic [7:0]  CMD_MASTER_CLEAR_PIN    = 8'h01;
    localparam logic [7:0]  CMD_PINSW   = 8'h02;
    localparam logic [7:0]  MODE_RESET  = 8'h00;
    // arbitrary identification word, bit 0 set as a tap id needs
    localparam logic [31:0] ID_DEFAULT  = 32'h1234_5001;

    typedef enum logic [3:0] {
        ST_RESET   = 4'b0000,
        ST_IDLE    = 4'b0001,
        ST_SEL_DR  = 4'b0010,
        ST_CAP_DR  = 4'b0011,
        ST_SHF_DR  = 4'b0100,
        ST_EX1_DR  = 4'b0101,
        ST_PAU_DR  = 4'b0110,
        ST_EX2_DR  = 4'b0111,
        ST_UPD_DR  = 4'b1000,
        ST_SEL_IR  = 4'b1001,
        ST_CAP_IR  = 4'b1010,
        ST_SHF_IR  = 4'b1011,
        ST_EX1_IR  = 4'b1100,
        ST_PAU_IR  = 4'b1101,
        ST_EX2_IR  = 4'b1110,
        ST_UPD_IR  = 4'b1111
    } bsil_state_t;

    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
    } bsil_tap_t;
endpackage

/* verilog/bsil_top.sv */
// Purpose: tap state machine, instruction decode, boundary chain and vendor commands
// Assumes: tck is much slower than clk_in and sampled through two flip-flops
// Notes:   tdo changes on the sampled tck falling edge, or follows prog_data_line_in every clock after the pin switch
module bsil_top import bsil_pkg::*; #(
    parameter int          PIN_COUNT   = 82,
    parameter int          MASTER_CLEAR_PIN_CYCLES = 16,
    parameter logic [31:0] ID_WORD     = ID_DEFAULT
) (
    // clock and reset
    input  wire logic                 clk_in,
    input  wire logic                 resetn_in,
    // tap pins
    input  wire logic                 tck_in,
    input  wire logic                 tms_in,
    input  wire logic                 tdi_in,
    output logic                      tdo_out,
    output logic                      tdo_oen_out,
    // core side of the pins
    input  wire logic [PIN_COUNT-1:0] core_out_in,
    input  wire logic [PIN_COUNT-1:0] core_oen_in,
    // pads
    input  wire logic [PIN_COUNT-1:0] pad_in_in,
    output logic      [PIN_COUNT-1:0] pad_out_out,
    output logic      [PIN_COUNT-1:0] pad_oen_out,
    // vendor functions
    output logic                      scan_master_clear_out,
    output logic                      serial_prog_pin_switch_out,
    output logic                      prog_std_only_out,
    output logic      [MODE_W-1:0]    vendor_mode_out,
    // serial programming lines
    output logic                      prog_clock_line_out,
    output logic                      prog_data_line_out,
    input  wire logic                 prog_data_line_in,
    input  wire logic                 prog_data_oen_in
);
    localparam int CHAIN_LEN = CELL_BITS * PIN_COUNT;
    localparam int CNT_W     = $clog2(MASTER_CLEAR_PIN_CYCLES + 1);

    // pin synchronisers
    bsil_tap_t              tap_s1;
    bsil_tap_t              tap_s2;
    logic                   tck_prev;
    logic [PIN_COUNT-1:0]   pad_s1;
    logic [PIN_COUNT-1:0]   pad_s2;

    // tap state
    bsil_state_t            state;
    bsil_state_t            next_state;
    logic [IR_W-1:0]        ir_sh;
    logic [IR_W-1:0]        next_ir_sh;
    logic [IR_W-1:0]        ir;
    logic [IR_W-1:0]        next_ir;
    logic                   byp;
    logic                   next_byp;
    logic [ID_W-1:0]        id_sh;
    logic [ID_W-1:0]        next_id_sh;
    logic [CMD_W-1:0]       cmd_sh;
    logic [CMD_W-1:0]       next_cmd_sh;
    logic [MODE_W-1:0]      mode_sh;
    logic [MODE_W-1:0]      next_mode_sh;
    logic [MODE_W-1:0]      mode;
    logic [MODE_W-1:0]      next_mode;
    logic [CHAIN_LEN-1:0]   chain;
    logic [CHAIN_LEN-1:0]   next_chain;
    logic [CHAIN_LEN-1:0]   cap_vec;
    logic [PIN_COUNT-1:0]   hold_out;
    logic [PIN_COUNT-1:0]   next_hold_out;
    logic [PIN_COUNT-1:0]   hold_oen;
    logic [PIN_COUNT-1:0]   next_hold_oen;
    logic [CNT_W-1:0]       master_clear_pin_cnt;
    logic [CNT_W-1:0]       next_master_clear_pin_cnt;
    logic                   pinsw;
    logic                   next_pinsw;
    logic                   next_tdo;
    logic                   next_tdo_oen;
    logic [PIN_COUNT-1:0]   next_pad_out;
    logic [PIN_COUNT-1:0]   next_pad_oen;

    logic tck_rise;
    logic tck_fall;
    logic tms;
    logic tdi;
    logic chain_sel;

    assign tck_rise  = tap_s2.tck & ~tck_prev;
    assign tck_fall  = ~tap_s2.tck & tck_prev;
    assign tms       = tap_s2.tms;
    assign tdi       = tap_s2.tdi;
    assign chain_sel = (ir == IR_SAMPLE) || (ir == IR_EXTEST);

    // capture vector: out, enable, input per cell
    genvar gi;
    generate
        for (gi = 0; gi < PIN_COUNT; gi++) begin : g_cell
            assign cap_vec[gi*CELL_BITS+CELL_OUT] = core_out_in[gi];
            assign cap_vec[gi*CELL_BITS+CELL_OE]  = core_oen_in[gi];
            assign cap_vec[gi*CELL_BITS+CELL_IN]  = pad_s2[gi];
        end
    endgenerate

    // next values on sampled tck edges
    always_comb begin
        next_state    = state;
        next_ir_sh    = ir_sh;
        next_ir       = ir;
        next_byp      = byp;
        next_id_sh    = id_sh;
        next_cmd_sh   = cmd_sh;
        next_mode_sh  = mode_sh;
        next_mode     = mode;
        next_chain    = chain;
        next_hold_out = hold_out;
        next_hold_oen = hold_oen;
        next_pinsw    = pinsw;
        next_master_clear_pin_cnt = (master_clear_pin_cnt != '0) ? master_clear_pin_cnt - CNT_W'(1) : master_clear_pin_cnt;
        next_tdo      = tdo_out;
        next_tdo_oen  = tdo_oen_out;
        if (tck_rise && !pinsw) begin
            // state transitions; tms high walks to reset in five rises
            case (state)
                ST_RESET:  next_state = tms ? ST_RESET  : ST_IDLE;
                ST_IDLE:   next_state = tms ? ST_SEL_DR : ST_IDLE;
                ST_SEL_DR: next_state = tms ? ST_SEL_IR : ST_CAP_DR;
                ST_CAP_DR: next_state = tms ? ST_EX1_DR : ST_SHF_DR;
                ST_SHF_DR: next_state = tms ? ST_EX1_DR : ST_SHF_DR;
                ST_EX1_DR: next_state = tms ? ST_UPD_DR : ST_PAU_DR;
                ST_PAU_DR: next_state = tms ? ST_EX2_DR : ST_PAU_DR;
                ST_EX2_DR: next_state = tms ? ST_UPD_DR : ST_SHF_DR;
                ST_UPD_DR: next_state = tms ? ST_SEL_DR : ST_IDLE;
                ST_SEL_IR: next_state = tms ? ST_RESET  : ST_CAP_IR;
                ST_CAP_IR: next_state = tms ? ST_EX1_IR : ST_SHF_IR;
                ST_SHF_IR: next_state = tms ? ST_EX1_IR : ST_SHF_IR;
                ST_EX1_IR: next_state = tms ? ST_UPD_IR : ST_PAU_IR;
                ST_PAU_IR: next_state = tms ? ST_EX2_IR : ST_PAU_IR;
                ST_EX2_IR: next_state = tms ? ST_UPD_IR : ST_SHF_IR;
                ST_UPD_IR: next_state = tms ? ST_SEL_DR : ST_IDLE;
                default:   next_state = ST_RESET;
            endcase
            // register actions in the state being left
            case (state)
                ST_RESET: begin
                    next_ir = IR_IDCODE;
                end
                ST_CAP_IR: begin
                    next_ir_sh = IR_CAPTURE;
                end
                ST_SHF_IR: begin
                    next_ir_sh = {tdi, ir_sh[IR_W-1:1]};
                end
                ST_UPD_IR: begin
                    next_ir = ir_sh;
                end
                ST_CAP_DR: begin
                    next_byp     = 1'b0;
                    next_id_sh   = ID_WORD;
                    next_mode_sh = mode;
                    if (chain_sel) begin
                        next_chain = cap_vec;
                    end
                end
                ST_SHF_DR: begin
                    if (chain_sel) begin
                        next_chain = {tdi, chain[CHAIN_LEN-1:1]};
                    end else if (ir == IR_IDCODE) begin
                        next_id_sh = {tdi, id_sh[ID_W-1:1]};
                    end else if (ir == IR_CMD) begin
                        next_cmd_sh = {tdi, cmd_sh[CMD_W-1:1]};
                    end else if (ir == IR_MODESCAN) begin
                        next_mode_sh = {tdi, mode_sh[MODE_W-1:1]};
                    end else begin
                        next_byp = tdi;
                    end
                end
                ST_UPD_DR: begin
                    if (chain_sel) begin
                        for (int i = 0; i < PIN_COUNT; i++) begin
                            next_hold_out[i] = chain[i*CELL_BITS+CELL_OUT];
                            next_hold_oen[i] = chain[i*CELL_BITS+CELL_OE];
                        end
                    end else if (ir == IR_MODESCAN) begin
                        next_mode = mode_sh;
                    end else if (ir == IR_CMD) begin
                        if (cmd_sh == CMD_MASTER_CLEAR_PIN) begin
                            next_master_clear_pin_cnt = CNT_W'(MASTER_CLEAR_PIN_CYCLES);
                        end else if (cmd_sh == CMD_PINSW) begin
                            next_pinsw = 1'b1;
                        end else begin
                            next_pinsw = pinsw;
                        end
                    end
                end
                default: begin
                end
            endcase
            // test-logic-reset releases the pins from any test instruction
            if (next_state == ST_RESET) begin
                next_ir = IR_IDCODE;
            end
        end

        // tdo from the selected register, or the programming answer
        if (pinsw) begin
            next_tdo     = prog_data_line_in;
            next_tdo_oen = prog_data_oen_in;
        end else if (tck_fall) begin
            next_tdo_oen = 1'b1;
            next_tdo     = 1'b0;
            if (state == ST_SHF_IR) begin
                next_tdo_oen = 1'b0;
                next_tdo     = ir_sh[0];
            end else if (state == ST_SHF_DR) begin
                next_tdo_oen = 1'b0;
                if (chain_sel) begin
                    next_tdo = chain[0];
                end else if (ir == IR_IDCODE) begin
                    next_tdo = id_sh[0];
                end else if (ir == IR_CMD) begin
                    next_tdo = cmd_sh[0];
                end else if (ir == IR_MODESCAN) begin
                    next_tdo = mode_sh[0];
                end else begin
                    next_tdo = byp;
                end
            end
        end

        // pad drive by instruction
        if (ir == IR_HIGHZ) begin
            next_pad_out = core_out_in;
            next_pad_oen = '1;
        end else if (ir == IR_EXTEST) begin
            next_pad_out = hold_out;
            next_pad_oen = hold_oen;
        end else begin
            next_pad_out = core_out_in;
            next_pad_oen = core_oen_in;
        end
    end

    // state registers
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            tap_s1                     <= '0;
            tap_s2                     <= '0;
            tck_prev                   <= 1'b0;
            pad_s1                     <= '0;
            pad_s2                     <= '0;
            state                      <= ST_RESET;
            ir_sh                      <= IR_CAPTURE;
            ir                         <= IR_IDCODE;
            byp                        <= 1'b0;
            id_sh                      <= ID_WORD;
            cmd_sh                     <= '0;
            mode_sh                    <= MODE_RESET;
            mode                       <= MODE_RESET;
            chain                      <= '0;
            hold_out                   <= '0;
            hold_oen                   <= '1;
            master_clear_pin_cnt                   <= '0;
            pinsw                      <= 1'b0;
            tdo_out                    <= 1'b0;
            tdo_oen_out                <= 1'b1;
            pad_out_out                <= '0;
            pad_oen_out                <= '1;
            scan_master_clear_out      <= 1'b0;
            serial_prog_pin_switch_out <= 1'b0;
            prog_std_only_out          <= 1'b0;
            vendor_mode_out            <= MODE_RESET;
            prog_clock_line_out        <= 1'b0;
            prog_data_line_out         <= 1'b0;
        end else begin
            tap_s1                     <= {tck_in, tms_in, tdi_in};
            tap_s2                     <= tap_s1;
            tck_prev                   <= tap_s2.tck;
            pad_s1                     <= pad_in_in;
            pad_s2                     <= pad_s1;
            state                      <= next_state;
            ir_sh                      <= next_ir_sh;
            ir                         <= next_ir;
            byp                        <= next_byp;
            id_sh                      <= next_id_sh;
            cmd_sh                     <= next_cmd_sh;
            mode_sh                    <= next_mode_sh;
            mode                       <= next_mode;
            chain                      <= next_chain;
            hold_out                   <= next_hold_out;
            hold_oen                   <= next_hold_oen;
            master_clear_pin_cnt                   <= next_master_clear_pin_cnt;
            pinsw                      <= next_pinsw;
            tdo_out                    <= next_tdo;
            tdo_oen_out                <= next_tdo_oen;
            pad_out_out                <= next_pad_out;
            pad_oen_out                <= next_pad_oen;
            scan_master_clear_out      <= (next_master_clear_pin_cnt != '0);
            serial_prog_pin_switch_out <= next_pinsw;
            prog_std_only_out          <= next_pinsw;
            vendor_mode_out            <= next_mode;
            prog_clock_line_out        <= next_pinsw & tap_s2.tck;
            prog_data_line_out         <= next_pinsw & tap_s2.tdi;
        end
    end
endmodule

/* verif/bsil_chk.sv */
// Purpose: port assertions for the boundary scan instruction logic
// Assumes: tck phases last at least four clk_in cycles
// Notes:   bound into bsil_top by the bench
module bsil_chk import bsil_pkg::*; #(
    parameter int MASTER_CLEAR_PIN_CYCLES = 16
) (
    // clock and reset
    input wire logic              clk_in,
    input wire logic              resetn_in,
    // tap side
    input wire logic              tck_in,
    input wire logic              tdo_out,
    input wire logic              tdo_oen_out,
    // vendor side
    input wire logic              scan_master_clear_out,
    input wire logic              serial_prog_pin_switch_out,
    input wire logic              prog_std_only_out,
    input wire logic [MODE_W-1:0] vendor_mode_out,
    input wire logic              prog_clock_line_out,
    input wire logic              prog_data_line_out,
    input wire logic              prog_data_line_in
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!resetn_in);
    // cycles the master clear has been high
    logic [15:0] hi_cnt;
    logic [15:0] next_hi_cnt;
    always_comb next_hi_cnt = scan_master_clear_out ? hi_cnt + 16'h0001 : 16'h0000;
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) hi_cnt <= 16'h0000;
        else hi_cnt <= next_hi_cnt;
    end
    property p_master_clear_pin_len;
        hi_cnt <= 16'(MASTER_CLEAR_PIN_CYCLES) and ($fell(scan_master_clear_out) |-> hi_cnt == 16'(MASTER_CLEAR_PIN_CYCLES));
    endproperty
    a_master_clear_pin_len: assert property (p_master_clear_pin_len) else $error("clear pulse length wrong");
    property p_master_clear_pin_rise; $rose(scan_master_clear_out) |-> $past(tck_in, 3); endproperty
    a_master_clear_pin_rise: assert property (p_master_clear_pin_rise) else $error("clear pulse off a tck rise");
    property p_sw_hold; serial_prog_pin_switch_out |=> serial_prog_pin_switch_out; endproperty
    a_sw_hold: assert property (p_sw_hold) else $error("pin switch dropped");
    property p_sw_rise; $rose(serial_prog_pin_switch_out) |-> $past(tck_in, 3); endproperty
    a_sw_rise: assert property (p_sw_rise) else $error("pin switch off a tck rise");
    property p_std_only; prog_std_only_out == serial_prog_pin_switch_out; endproperty
    a_std_only: assert property (p_std_only) else $error("standard only flag wrong");
    property p_prog_idle; !serial_prog_pin_switch_out |-> !prog_clock_line_out && !prog_data_line_out; endproperty
    a_prog_idle: assert property (p_prog_idle) else $error("prog lines active unswitched");
    property p_tdo_copy;
        serial_prog_pin_switch_out && $past(serial_prog_pin_switch_out, 2) && $stable(prog_data_line_in)
            && $past(prog_data_line_in, 2) == prog_data_line_in |-> tdo_out == prog_data_line_in;
    endproperty
    a_tdo_copy: assert property (p_tdo_copy) else $error("tdo not prog data");
    property p_tdo_edge; !serial_prog_pin_switch_out && $changed(tdo_out) |-> !$past(tck_in, 2); endproperty
    a_tdo_edge: assert property (p_tdo_edge) else $error("tdo moved off a tck fall");
    property p_mode_upd; $changed(vendor_mode_out) |-> $past(tck_in, 3); endproperty
    a_mode_upd: assert property (p_mode_upd) else $error("mode moved off a tck rise");
    c_master_clear_pin: cover property ($rose(scan_master_clear_out));
    c_switch: cover property ($rose(serial_prog_pin_switch_out));
    c_shift: cover property ($fell(tdo_oen_out));
endmodule

/* verif/bsil_tester.sv */
// Purpose: behavioural tester driving the tap pins
// Assumes: tck period of eight clk_in cycles
// Notes:   tck stands low and tdi toggles between frames
module bsil_tester (
    // clock
    input  wire logic clk_in,
    // tap pins
    input  wire logic tdo_in,
    input  wire logic tdo_oen_in,
    output logic      tck_out,
    output logic      tms_out,
    output logic      tdi_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic tgl = 1'b0;
    initial begin
        tck_out = 1'b0;
        tms_out = 1'b1;
        tdi_out = 1'b0;
    end
    // one tck period, tdo read just before the fall
    task automatic pulse(input logic ms, input logic di, output logic dout);
        @(negedge clk_in);
        tms_out = ms;
        tdi_out = di;
        repeat (3) @(negedge clk_in);
        tck_out = 1'b1;
        repeat (4) @(negedge clk_in);
        dout = tdo_oen_in ? 1'bx : tdo_in;
        tck_out = 1'b0;
    endtask
    task automatic step(input logic ms);
        logic d;
        tgl = ~tgl;
        pulse(ms, tgl, d);
    endtask
    task automatic reset_tap();
        repeat (5) step(1'b1);
        step(1'b0);
    endtask
    // from idle through one scan back to idle
    task automatic scan(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
        logic b;
        dout = 32'h0000_0000;
        step(1'b1);
        if (ir) step(1'b1);
        step(1'b0);
        step(1'b0);
        for (int i = 0; i < n; i++) begin
            pulse(i == n - 1, din[i], b);
            dout[i] = b;
        end
        step(1'b1);
        step(1'b0);
    endtask
    task automatic hold(input logic c, input logic d);
        @(negedge clk_in);
        tck_out = c;
        tdi_out = d;
    endtask
endmodule

/* verif/tb_bsil_top.sv */
// Purpose: self-checking bench for the boundary scan instruction logic
// Assumes: four pins, tck of 80 ns made by the tester model
// Notes:   expectations come from the pin values the bench drives
module tb_bsil_top import bsil_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PINS = 4;
    localparam int MASTER_CLEAR_PIN = 16;
    localparam int NB   = 3 * PINS;
    logic            clk = 1'b0;
    logic            resetn, tck, tms, tdi, tdo, tdo_oen;
    logic            master_clear_pin, pinsw, stdonly, pclk, pdat, pdat_in, pdat_oen;
    logic [PINS-1:0] core_out, core_oen, pad_in, pad_out, pad_oen;
    logic [7:0]      mode;
    logic [31:0]     got, pat;
    int              num_errors = 0;
    int              comparisons = 0;
    int              seed = 78611;
    int              master_clear_pin_cnt = 0;
    always #5 clk = ~clk;
    always @(posedge clk) if (master_clear_pin === 1'b1) master_clear_pin_cnt++;
    bsil_top #(.PIN_COUNT(PINS), .MASTER_CLEAR_PIN_CYCLES(MASTER_CLEAR_PIN)) bsil_top_i (
        .clk_in(clk), .resetn_in(resetn), .tck_in(tck), .tms_in(tms), .tdi_in(tdi), .tdo_out(tdo),
        .tdo_oen_out(tdo_oen), .core_out_in(core_out), .core_oen_in(core_oen), .pad_in_in(pad_in),
        .pad_out_out(pad_out), .pad_oen_out(pad_oen), .scan_master_clear_out(master_clear_pin),
        .serial_prog_pin_switch_out(pinsw), .prog_std_only_out(stdonly), .vendor_mode_out(mode),
        .prog_clock_line_out(pclk), .prog_data_line_out(pdat), .prog_data_line_in(pdat_in),
        .prog_data_oen_in(pdat_oen));
    bsil_tester bsil_tester_i (.clk_in(clk), .tdo_in(tdo), .tdo_oen_in(tdo_oen), .tck_out(tck),
        .tms_out(tms), .tdi_out(tdi));
    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        comparisons++;
        if (seen !== want) begin
            num_errors++;
            $display("[ERR] %0t seen %h want %h", $time, seen, want);
        end
    endtask
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic ld(input logic [3:0] code);
        bsil_tester_i.scan(1'b1, 4, 32'(code), got);
        chk(32'(got[3:0]), 32'(IR_CAPTURE));
    endtask
    task automatic dr(input int n, input logic [31:0] din);
        bsil_tester_i.scan(1'b0, n, din, got);
    endtask
    task automatic rnd();
        @(negedge clk);
        core_out = PINS'($random(seed));
        core_oen = PINS'($random(seed));
        pad_in   = PINS'($random(seed));
        pdat_in  = 1'($random(seed));
        pdat_oen = 1'($random(seed));
    endtask
    task automatic chk_cap(input logic [31:0] c, input logic full);
        for (int i = 0; i < PINS; i++) begin
            if (full) begin
                chk(32'(c[3*i]), 32'(core_out[i]));
                chk(32'(c[3*i+1]), 32'(core_oen[i]));
            end
            chk(32'(c[3*i+2]), 32'(pad_in[i]));
        end
    endtask
    task automatic chk_pads(input logic [31:0] c);
        for (int i = 0; i < PINS; i++) begin
            chk(32'({pad_oen[i], pad_out[i]}), 32'({c[3*i+1], c[3*i]}));
        end
    endtask
    initial begin
        resetn = 1'b0;
        core_out = '0;
        core_oen = '1;
        pad_in = '0;
        pdat_in = 1'b0;
        pdat_oen = 1'b1;
        repeat (10) @(negedge clk);
        resetn = 1'b1;
        rnd();
        bsil_tester_i.reset_tap();
        dr(32, 32'h0000_0000);
        chk(got, ID_DEFAULT);
        ld(IR_SAMPLE);
        pat = $random(seed);
        dr(NB + 4, pat);
        chk_cap(got, 1'b1);
        chk(32'(got[NB+3 -: 4]), 32'(pat[3:0]));
        chk(32'({pad_oen, pad_out}), 32'({core_oen, core_out}));
        ld(IR_EXTEST);
        chk_pads(pat >> 4);
        rnd();
        pat = $random(seed);
        dr(NB, pat);
        chk_cap(got, 1'b0);
        chk_pads(pat);
        ld(IR_HIGHZ);
        chk(32'(pad_oen), 32'({PINS{1'b1}}));
        for (int k = 0; k < 2; k++) begin
            ld(k == 0 ? IR_BYPASS : 4'h5);
            dr(8, 32'h0000_00b6);
            chk(got, 32'h0000_006c);
        end
        ld(IR_MODESCAN);
        pat = 32'(8'($random(seed)));
        dr(8, pat);
        chk(32'(mode), pat);
        dr(8, ~pat);
        chk(got, pat);
        ld(IR_CMD);
        dr(8, 32'h0000_0003);
        dr(8, 32'h0000_0080);
        chk(32'({master_clear_pin_cnt[7:0], pinsw, mode}), 32'({8'h00, 1'b0, ~pat[7:0]}));
        dr(8, 32'(CMD_MASTER_CLEAR_PIN));
        repeat (30) @(negedge clk);
        chk(master_clear_pin_cnt, MASTER_CLEAR_PIN);
        dr(8, 32'(CMD_PINSW));
        chk(32'({pinsw, stdonly}), 32'h0000_0003);
        for (int k = 0; k < 4; k++) begin
            bsil_tester_i.hold(k[0], k[1]);
            rnd();
            repeat (5) @(negedge clk);
            chk(32'({pclk, pdat}), 32'({k[0], k[1]}));
            chk(32'({tdo_oen, tdo}), 32'({pdat_oen, pdat_in}));
        end
        resetn = 1'b0;
        repeat (3) @(negedge clk);
        chk(32'({pinsw, tdo_oen, pad_oen}), 32'({2'b01, {PINS{1'b1}}}));
        wrap_up();
    end
    initial begin
        #300us;
        num_errors++;
        wrap_up();
    end
endmodule
bind bsil_top bsil_chk #(.MASTER_CLEAR_PIN_CYCLES(MASTER_CLEAR_PIN_CYCLES)) bsil_chk_i (.clk_in(clk_in), .resetn_in(resetn_in),
    .tck_in(tck_in), .tdo_out(tdo_out), .tdo_oen_out(tdo_oen_out), .scan_master_clear_out(scan_master_clear_out),
    .serial_prog_pin_switch_out(serial_prog_pin_switch_out), .prog_std_only_out(prog_std_only_out),
    .vendor_mode_out(vendor_mode_out), .prog_clock_line_out(prog_clock_line_out),
    .prog_data_line_out(prog_data_line_out), .prog_data_line_in(prog_data_line_in));
